/* File: backup_gate_cfg.svh */
/*
  Constants for the backup-mode bus gating block.
  Assumes inclusion by bare name; definitions only.
*/
`ifndef BACKUP_GATE_CFG_SVH
`define BACKUP_GATE_CFG_SVH
`define SWITCHOVER_SELECT_RST 1'h0
`define BACKUP_BUS_DISABLE_RST 1'h0
`define TRIP_THRESHOLD_MV 2200
`define SETTLE_TIME_NS 100
`define CLK_PERIOD_NS 25
`define SETTLE_CYCLES ((`SETTLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* File: backup_gate_pkg.sv */
/*
  Types for the backup-mode bus gating block.
  Assumes no other package.
*/
package backup_gate_pkg;
  typedef enum logic [1:0] {
    MODE_STD_BUS,
    MODE_LEGACY_BUS,
    MODE_STD_NOBUS,
    MODE_LEGACY_NOBUS
  } backup_mode_t;
  typedef enum {
    SUPPLY_MAIN,
    SUPPLY_BACKUP
  } supply_state_t;
endpackage : backup_gate_pkg

/* File: supply_switch_filter.sv */
/*
  Qualifies a raw switchover condition: it must hold a fixed number
  of cycles before the filtered flag follows it.
  Assumes the condition is synchronous to clk_sys.
*/
`timescale 1ns/100ps
module supply_switch_filter #(
  parameter int SETTLE = 4
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic raw_cond,
  output logic      filtered
);
  localparam int CW = $clog2(SETTLE + 1);
  logic [CW-1:0] count;

  // Comparator chatter near the threshold must not toggle the bus gate
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      count    <= '0;
      filtered <= 1'b0;
    end else if (raw_cond == filtered) begin
      count <= '0;
    end else if (count == CW'(SETTLE - 1)) begin
      count    <= '0;
      filtered <= raw_cond;
    end else begin
      count <= count + CW'(1);
    end
  end
endmodule : supply_switch_filter

/* File: backup_mode_bus_gating.sv */
/*
  Battery switchover decision and serial bus gating in backup.
  Assumes supply comparisons arrive as synchronous digital flags and
  the two mode bits are held stable by the configuration logic.
  The bus engine outside raises sda_ack_req whenever it wants the line
  low; this block only decides whether that request reaches the pin.
  Limitation: no memory access path is modelled in backup in any mode.
*/
`timescale 1ns/100ps
`include "backup_gate_cfg.svh"

// Function
// - Mode 00: standard switchover, bus stays alive
// - Standard: backup below lower of threshold, battery
// - Legacy: backup only when supply below battery
// - Disable bit: bus off in backup
// - Alarm output works in every mode
// - Legacy with bus matches predecessor behaviour
// - Power-up default is standard switchover
module backup_mode_bus_gating #(
  parameter int SETTLE = `SETTLE_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic switchover_select_in,
  input  wire logic backup_bus_disable_in,
  input  wire logic cfg_load,
  input  wire logic vdd_below_trip,
  input  wire logic vdd_below_vbat,
  input  wire logic alarm_req,
  input  wire logic sda_in,
  input  wire logic sda_ack_req,
  output logic      switchover_select,
  output logic      backup_bus_disable,
  output logic      on_battery,
  output logic      bus_enable,
  output logic      sda_out,
  output logic      sda_oe,
  output logic      alarm_freq_out,
  output logic      alarm_freq_oe,
  output logic [1:0] mode
);
  logic                           raw_backup;
  logic                           backup_flt;
  backup_gate_pkg::backup_mode_t  next_mode;
  backup_gate_pkg::supply_state_t supply;
  backup_gate_pkg::supply_state_t next_supply;

  function automatic logic switch_cond(
    input logic legacy,
    input logic below_trip,
    input logic below_bat
  );
    // Below the lower of two levels means below both
    if (legacy) begin
      switch_cond = below_bat;
    end else begin
      switch_cond = below_trip & below_bat;
    end
  endfunction : switch_cond

  function automatic backup_gate_pkg::backup_mode_t decode_mode(
    input logic bus_off,
    input logic legacy
  );
    case ({bus_off, legacy})
      2'h0: begin
        decode_mode = backup_gate_pkg::MODE_STD_BUS;
      end
      2'h1: begin
        decode_mode = backup_gate_pkg::MODE_LEGACY_BUS;
      end
      2'h2: begin
        decode_mode = backup_gate_pkg::MODE_STD_NOBUS;
      end
      2'h3: begin
        decode_mode = backup_gate_pkg::MODE_LEGACY_NOBUS;
      end
      default: begin
        decode_mode = backup_gate_pkg::MODE_STD_BUS;
      end
    endcase
  endfunction : decode_mode

  // One place decides whether the bus is cut, so gate and pin agree
  function automatic logic gate_closed(
    input backup_gate_pkg::supply_state_t state,
    input logic                           bus_off
  );
    gate_closed = (state == backup_gate_pkg::SUPPLY_BACKUP) && bus_off;
  endfunction : gate_closed

  // Mode bits written by configuration; reset gives standard with bus
  // Bits may change in backup; the gate follows the disable bit one cycle later
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      switchover_select <= `SWITCHOVER_SELECT_RST;
    end else if (cfg_load) begin
      switchover_select <= switchover_select_in;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      backup_bus_disable <= `BACKUP_BUS_DISABLE_RST;
    end else if (cfg_load) begin
      backup_bus_disable <= backup_bus_disable_in;
    end
  end

  always_comb begin
    raw_backup = switch_cond(switchover_select, vdd_below_trip, vdd_below_vbat);
  end

  // Settling keeps a slow supply ramp from flapping the gate
  supply_switch_filter #(
    .SETTLE (SETTLE)
  ) u_filter (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .raw_cond (raw_backup),
    .filtered (backup_flt)
  );

  // Supply state follows the settled switchover condition
  always_comb begin
    next_supply = supply;
    case (supply)
      backup_gate_pkg::SUPPLY_MAIN: begin
        if (backup_flt) begin
          next_supply = backup_gate_pkg::SUPPLY_BACKUP;
        end
      end
      backup_gate_pkg::SUPPLY_BACKUP: begin
        if (!backup_flt) begin
          next_supply = backup_gate_pkg::SUPPLY_MAIN;
        end
      end
      default: begin
        next_supply = backup_gate_pkg::SUPPLY_MAIN;
      end
    endcase
  end

  // Power-up always starts on main supply
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      supply <= backup_gate_pkg::SUPPLY_MAIN;
    end else begin
      supply <= next_supply;
    end
  end

  always_comb begin
    next_mode = decode_mode(backup_bus_disable, switchover_select);
  end

  // Mode word lags the bits by one cycle; a status copy only
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mode <= 2'h0;
    end else begin
      mode <= next_mode;
    end
  end

  // Status copy of the supply state, one cycle after settling
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      on_battery <= 1'b0;
    end else begin
      on_battery <= (next_supply == backup_gate_pkg::SUPPLY_BACKUP);
    end
  end

  // Bus gate reopens as soon as main supply returns
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bus_enable <= 1'b1;
    end else begin
      bus_enable <= !gate_closed(next_supply, backup_bus_disable);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  // Open drain: only ever pulls low, never acknowledges while gated
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sda_oe <= 1'b0;
    end else begin
      sda_oe <= sda_ack_req && !gate_closed(next_supply, backup_bus_disable);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      alarm_freq_out <= 1'b0;
    end else begin
      alarm_freq_out <= 1'b0;
    end
  end

  // Alarm path has no dependence on supply or mode
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      alarm_freq_oe <= 1'b0;
    end else begin
      alarm_freq_oe <= alarm_req;
    end
  end

  // Line level is observed elsewhere; kept as a port for the bus front end
  logic unused_sda;
  assign unused_sda = sda_in;
endmodule : backup_mode_bus_gating

/* File: backup_gate_chk.sv */
/* Assertions on the backup bus gating ports.
   Assumes binding into backup_mode_bus_gating, one clock domain. */
`timescale 1ns/100ps
module backup_gate_chk #(parameter int SETTLE = 4) (
  input wire logic clk_sys, rst_n, switchover_select_in, backup_bus_disable_in,
  input wire logic cfg_load, vdd_below_trip, vdd_below_vbat, alarm_req, sda_ack_req,
  input wire logic switchover_select, backup_bus_disable, on_battery, bus_enable,
  input wire logic sda_oe, alarm_freq_out, alarm_freq_oe,
  input wire logic [1:0] mode
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_load; cfg_load ##2 1'h1; endsequence
  property p_rst; $rose(rst_n) |-> !on_battery && bus_enable && mode == 2'h0; endproperty
  property p_mode;
    s_load |-> mode == {$past(backup_bus_disable_in, 2), $past(switchover_select_in, 2)};
  endproperty
  property p_std; $rose(on_battery) && !switchover_select |-> $past(vdd_below_trip); endproperty
  property p_leg; $rose(on_battery) |-> $past(vdd_below_vbat); endproperty
  property p_gate;
    on_battery && $past(backup_bus_disable) |-> !bus_enable && !sda_oe;
  endproperty
  property p_ack; sda_ack_req && !backup_bus_disable |=> sda_oe; endproperty
  property p_alarm; alarm_req |=> alarm_freq_oe && !alarm_freq_out; endproperty
  property p_bus; !$past(backup_bus_disable) |-> bus_enable; endproperty
  property p_resume; $fell(on_battery) |-> bus_enable; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  a_mode: assert property (p_mode) else $error("mode not loaded");
  a_std: assert property (p_std) else $error("early standard switch");
  a_leg: assert property (p_leg) else $error("switch above battery");
  a_gate: assert property (p_gate) else $error("bus alive in backup");
  a_ack: assert property (p_ack) else $error("ack lost");
  a_alarm: assert property (p_alarm) else $error("alarm dead");
  a_bus: assert property (p_bus) else $error("bus gated wrongly");
  a_resume: assert property (p_resume) else $error("bus not resumed");
endmodule : backup_gate_chk
bind backup_mode_bus_gating backup_gate_chk #(.SETTLE(SETTLE)) u_backup_gate_chk (.*);

/* File: bus_host_model.sv */
/* Bus host stand-in on the shared data line.
   Assumes a pull-up on the line, open-drain parties. */
`timescale 1ns/100ps
module bus_host_model (
  input  wire logic host_low,
  input  wire logic sda_oe,
  output logic      sda_in
);
  // Pull-up: any party pulling low wins
  assign sda_in = !(host_low || sda_oe);
endmodule : bus_host_model

/* File: backup_mode_bus_gating_bench.sv */
/* Self-checking bench sweeping all four backup modes.
   Assumes the default settle count; backup follows SETTLE+1 edges after the flags. */
`timescale 1ns/100ps
module backup_mode_bus_gating_bench;
  localparam int SETTLE = 4;
  localparam int LAT = SETTLE + 1;
  logic clk_sys = 0, rst_n = 0, switchover_select_in = 0, backup_bus_disable_in = 0;
  logic cfg_load = 0, vdd_below_trip = 0, vdd_below_vbat = 0, alarm_req = 0;
  logic sda_ack_req = 0, host_low = 0, sda_in, switchover_select, backup_bus_disable;
  logic on_battery, bus_enable, sda_out, sda_oe, alarm_freq_out, alarm_freq_oe;
  logic [1:0] mode;
  int fails = 0, samples_checked = 0;
  initial forever #12.5 clk_sys = ~clk_sys;
  backup_mode_bus_gating #(.SETTLE(SETTLE)) u_backup_mode_bus_gating (.*);
  bus_host_model u_bus_host_model (.*);
  task automatic check(input logic [3:0] seen, input logic [3:0] want);
    samples_checked++;
    if (seen !== want) begin
      fails++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic print_verdict;
    if (fails == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  task automatic t_reset;
    repeat (5) @(negedge clk_sys);
    rst_n = 1;
    @(negedge clk_sys);
    check({switchover_select, on_battery, bus_enable, alarm_freq_oe}, 4'h2);
    check({sda_out, sda_oe, mode}, 4'h0);
    host_low = 1;
    @(negedge clk_sys);
    check({3'h0, sda_in}, 4'h0);
    host_low = 0;
  endtask : t_reset
  task automatic t_mode(input logic [1:0] m);
    {backup_bus_disable_in, switchover_select_in, cfg_load} = {m, 1'h1};
    @(negedge clk_sys);
    cfg_load = 0;
    @(negedge clk_sys);
    check({switchover_select, backup_bus_disable, mode}, {m[0], m[1], m});
    {vdd_below_vbat, alarm_req, sda_ack_req} = 3'h7;
    repeat (LAT - 1) @(negedge clk_sys);
    check({sda_out, alarm_freq_out, bus_enable, on_battery}, 4'h2);
    @(negedge clk_sys);
    check({on_battery, bus_enable, sda_in, alarm_freq_oe}, {m[0], !(&m), &m, 1'h1});
    vdd_below_trip = 1;
    repeat (LAT) @(negedge clk_sys);
    check({on_battery, bus_enable, sda_in, alarm_freq_oe}, {1'h1, !m[1], m[1], 1'h1});
    {vdd_below_trip, vdd_below_vbat} = 2'h0;
    repeat (LAT) @(negedge clk_sys);
    check({on_battery, bus_enable, sda_in, alarm_freq_out}, 4'h4);
    {alarm_req, sda_ack_req} = 2'h0;
  endtask : t_mode
  initial begin
    t_reset;
    for (int i = 0; i < 4; i++) t_mode(i[1:0]);
    print_verdict;
  end
  initial begin
    #5000;
    fails++;
    print_verdict;
  end
endmodule : backup_mode_bus_gating_bench
